// File: rtl/tcu_pkg.sv
// Purpose: Shared constants, types and helpers of the timer/counter unit.
// Assumes: Byte-wide special function register bus, one system clock.
// Notes: Addresses are the register bus byte addresses.
package tcu_pkg;

    // Register addresses
    localparam logic [7:0] TCU_ADDR_T01_MODE = 8'h89;
    localparam logic [7:0] TCU_ADDR_T0_LOW = 8'h8A;
    localparam logic [7:0] TCU_ADDR_T1_LOW = 8'h8B;
    localparam logic [7:0] TCU_ADDR_T0_HIGH = 8'h8C;
    localparam logic [7:0] TCU_ADDR_T1_HIGH = 8'h8D;
    localparam logic [7:0] TCU_ADDR_T2_CTRL = 8'hC8;
    localparam logic [7:0] TCU_ADDR_T2_RC_LOW = 8'hCA;
    localparam logic [7:0] TCU_ADDR_T2_RC_HIGH = 8'hCB;
    localparam logic [7:0] TCU_ADDR_T2_LOW = 8'hCC;
    localparam logic [7:0] TCU_ADDR_T2_HIGH = 8'hCD;
    localparam logic [7:0] TCU_ADDR_AUXILIARY_CONTROL_ONE = 8'hF8;

    // Values after reset and on unmapped reads
    localparam logic [7:0] TCU_RESET_BYTE = 8'h00;
    localparam logic [7:0] TCU_UNMAPPED_BYTE = 8'h00;

    // Field positions in the timer 0/1 mode register
    localparam int TCU_T1_CTR_SEL_POS = 6;
    localparam int TCU_T1_MODE_POS = 4;
    localparam int TCU_T0_CTR_SEL_POS = 2;
    localparam int TCU_T0_MODE_POS = 0;

    // Field positions in the auxiliary control register
    localparam int TCU_AUX_T2_SRC_POS = 2;
    localparam int TCU_AUX_T1_SRC_POS = 1;

    // Cycle counts
    localparam int TCU_SYS_TICK_DIV = 2;
    localparam int TCU_SLOW_DIV = 16;

    // Timer 0/1 mode field encodings
    localparam logic [1:0] TCU_MODE_PRESCALE = 2'h0;
    localparam logic [1:0] TCU_MODE_16BIT = 2'h1;
    localparam logic [1:0] TCU_MODE_AUTO8 = 2'h2;
    localparam logic [1:0] TCU_MODE_STOP = 2'h3;

    // Prescaler of the 8-bit mode is the low five bits of the low byte
    localparam logic [7:0] TCU_PRESCALE_MASK = 8'h1F;

    // Edge input lanes
    localparam int TCU_EDGE_T0 = 0;
    localparam int TCU_EDGE_T1 = 1;
    localparam int TCU_EDGE_T2 = 2;
    localparam int TCU_EDGE_TRIG = 3;
    localparam int TCU_EDGE_SLOW = 4;
    localparam int TCU_EDGE_COUNT = 5;

    // Timer 2 control register, bit 7 first
    typedef struct packed {
        logic ovf_flag;
        logic ext_flag;
        logic rx_baud;
        logic tx_baud;
        logic ext_en;
        logic run;
        logic ctr_sel;
        logic cap_mode;
    } tcu_t2ctl_type;

    typedef struct packed {
        logic ovf;
        logic [15:0] count;
    } tcu_step_type;

    // One step of timer 0 or timer 1 in the given mode
    function automatic tcu_step_type tcu_t01_step(input logic [1:0] mode,
                                                  input logic [15:0] cnt,
                                                  input logic tick);
        tcu_step_type res;
        res.ovf = 1'b0;
        res.count = cnt;
        if (tick) begin
            case (mode)
                TCU_MODE_PRESCALE: begin
                    res.count[7:0] = (cnt[7:0] & ~TCU_PRESCALE_MASK)
                                   | ((cnt[7:0] + 8'h01) & TCU_PRESCALE_MASK);
                    if ((cnt[7:0] & TCU_PRESCALE_MASK) == TCU_PRESCALE_MASK) begin
                        res.count[15:8] = cnt[15:8] + 8'h01;
                        res.ovf = (cnt[15:8] == 8'hFF);
                    end
                end
                TCU_MODE_16BIT: begin
                    res.count = cnt + 16'h0001;
                    res.ovf = (cnt == 16'hFFFF);
                end
                TCU_MODE_AUTO8: begin
                    res.ovf = (cnt[7:0] == 8'hFF);
                    res.count[7:0] = res.ovf ? cnt[15:8] : cnt[7:0] + 8'h01;
                end
                default: begin
                    res.count = cnt;
                end
            endcase
        end
        return res;
    endfunction : tcu_t01_step

endpackage : tcu_pkg

// File: rtl/tcu_fall_sync.sv
// Purpose: Synchronise pin inputs and flag their falling edges.
// Assumes: Pins are asynchronous to sys_clk_i and held at least two cycles per level.
// Notes: One pulse per falling edge, three cycles after the pin falls.
`timescale 1ns/1ps
`default_nettype none
module tcu_fall_sync
    import tcu_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] fall_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] last;

    // Resets high so an idle-high pin gives no false edge
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta <= '1;
            stable <= '1;
            last <= '1;
        end else begin
            meta <= pin_i;
            stable <= meta;
            last <= stable;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fall_o <= '0;
        end else begin
            fall_o <= last & ~stable;
        end
    end
endmodule : tcu_fall_sync
`default_nettype wire

// File: rtl/tcu_slow_div.sv
// Purpose: Divide the slow clock edge pulses into one tick per DIV edges.
// Assumes: Edge pulses already synchronised to the system clock.
// Notes: Tick is a one-cycle enable, never a clock.
`timescale 1ns/1ps
`default_nettype none
module tcu_slow_div
    import tcu_pkg::*;
#(
    parameter int DIV = TCU_SLOW_DIV
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic edge_i,
    output logic tick_o
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt;

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt <= '0;
            tick_o <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (edge_i) begin
                cnt <= (cnt == LAST) ? '0 : cnt + 1'b1;
                tick_o <= (cnt == LAST);
            end
        end
    end
endmodule : tcu_slow_div
`default_nettype wire

// File: rtl/tcu_top.sv
// Purpose: Timer/counter unit: timers 0 and 1 count bytes, timer 2 and baud select.
// Assumes: CPU register bus on sys_clk_i; reads return data the cycle after.
// Notes: Run enables of timers 0/1 come from the CPU timer control logic.
// Functional notes
// - Timer 0 low/high bytes, read/write, reset zero
// - Timer 1 low/high bytes, read/write, reset zero
// - Timer 1 counter input: pin or slow/16
// - Timer 2 count and reload/capture, byte split
// - Timer 2 overflow flag unless baud use
// - Enabled trigger fall: capture/reload, external flag
// - Timer 2 counts only while run set
// - Timer 2 ticks every 2 cycles, pin falls or slow/16
// - Receive baud from timer 2 or timer 1
// - Transmit baud from timer 2 or timer 1
// - Timers 0/1 tick every 2 cycles
// - Timers 0/1 counter mode counts pin falls, or slow/16 for timer 1
// - Mode 00: 8-bit counter, 5-bit prescaler
// - Mode 01: one 16-bit counter
`timescale 1ns/1ps
`default_nettype none
module tcu_top
    import tcu_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    input wire logic timer0_run_i,
    input wire logic timer1_run_i,
    input wire logic timer0_ext_count_pin_i,
    input wire logic timer1_ext_count_pin_i,
    input wire logic timer2_ext_count_pin_i,
    input wire logic timer2_trigger_pin_i,
    input wire logic slow_oscillator_clock_i,
    output logic timer0_overflow_o,
    output logic timer1_overflow_o,
    output logic timer2_overflow_o,
    output logic uart_rx_baud_tick_o,
    output logic uart_tx_baud_tick_o
);
    // Shared rate divider
    localparam int SYS_CW = $clog2(TCU_SYS_TICK_DIV);
    localparam logic [SYS_CW-1:0] SYS_LAST = SYS_CW'(TCU_SYS_TICK_DIV - 1);

    // Register state
    logic [7:0] t01_mode;
    logic [7:0] auxiliary_control_one;
    logic [15:0] t0_count;
    logic [15:0] t1_count;
    logic [15:0] t2_count;
    logic [15:0] t2_rc;
    tcu_t2ctl_type t2_ctl;
    tcu_t2ctl_type next_t2_ctl;

    // Timing sources
    logic [SYS_CW-1:0] sys_div;
    logic sys_tick;
    logic [TCU_EDGE_COUNT-1:0] pin_fall;
    logic slow_tick;

    // Write decode
    logic wr_t0_low;
    logic wr_t0_high;
    logic wr_t1_low;
    logic wr_t1_high;
    logic wr_t2_low;
    logic wr_t2_high;
    logic wr_rc_low;
    logic wr_rc_high;

    // Timer datapath
    logic t0_tick;
    logic t1_tick;
    logic t2_tick;

    logic t1_src;
    logic t2_src;

    tcu_step_type t0_step;
    tcu_step_type t1_step;
    logic t0_ovf;
    logic t1_ovf;

    // Timer 2 datapath
    logic t2_baud;
    logic t2_auto;
    logic t2_ovf;
    logic t2_trig;
    logic t2_reload;
    logic t2_capture;
    logic [15:0] next_t2_count;

    tcu_fall_sync #(
        .WIDTH(TCU_EDGE_COUNT)
    ) u_fall_sync (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i({slow_oscillator_clock_i,
                timer2_trigger_pin_i,
                timer2_ext_count_pin_i,
                timer1_ext_count_pin_i,
                timer0_ext_count_pin_i}),
        .fall_o(pin_fall)
    );

    // Slow clock is only ever counted, never used as a clock here
    tcu_slow_div #(
        .DIV(TCU_SLOW_DIV)
    ) u_slow_div (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .edge_i(pin_fall[TCU_EDGE_SLOW]),
        .tick_o(slow_tick)
    );

    // Shared timer-mode rate: one tick every two system clocks
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sys_div <= '0;
        end else begin
            sys_div <= (sys_div == SYS_LAST) ? '0 : sys_div + 1'b1;
        end
    end
    // Phase runs free from reset
    assign sys_tick = (sys_div == SYS_LAST);

    // Write strobes
    assign wr_t0_low = sfr_wr_i && (sfr_addr_i == TCU_ADDR_T0_LOW);
    assign wr_t0_high = sfr_wr_i && (sfr_addr_i == TCU_ADDR_T0_HIGH);
    assign wr_t1_low = sfr_wr_i && (sfr_addr_i == TCU_ADDR_T1_LOW);
    assign wr_t1_high = sfr_wr_i && (sfr_addr_i == TCU_ADDR_T1_HIGH);

    // Timer 2 byte strobes
    assign wr_t2_low = sfr_wr_i && (sfr_addr_i == TCU_ADDR_T2_LOW);
    assign wr_t2_high = sfr_wr_i && (sfr_addr_i == TCU_ADDR_T2_HIGH);
    assign wr_rc_low = sfr_wr_i && (sfr_addr_i == TCU_ADDR_T2_RC_LOW);
    assign wr_rc_high = sfr_wr_i && (sfr_addr_i == TCU_ADDR_T2_RC_HIGH);

    // Mode register; gate bits stored only
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            t01_mode <= TCU_RESET_BYTE;
        end else if (sfr_wr_i && (sfr_addr_i == TCU_ADDR_T01_MODE)) begin
            t01_mode <= sfr_wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            auxiliary_control_one <= TCU_RESET_BYTE;
        end else if (sfr_wr_i && (sfr_addr_i == TCU_ADDR_AUXILIARY_CONTROL_ONE)) begin
            auxiliary_control_one <= sfr_wdata_i;
        end
    end

    // Timers 0 and 1 tick sources
    assign t1_src = auxiliary_control_one[TCU_AUX_T1_SRC_POS] ? slow_tick : pin_fall[TCU_EDGE_T1];
    assign t0_tick = timer0_run_i && (t01_mode[TCU_T0_CTR_SEL_POS]
                     ? pin_fall[TCU_EDGE_T0] : sys_tick);
    assign t1_tick = timer1_run_i && (t01_mode[TCU_T1_CTR_SEL_POS]
                     ? t1_src : sys_tick);

    // Mode 00 prescaler and mode 01 16-bit chain live in the step function
    assign t0_step = tcu_t01_step(t01_mode[TCU_T0_MODE_POS +: 2], t0_count, t0_tick);
    assign t1_step = tcu_t01_step(t01_mode[TCU_T1_MODE_POS +: 2], t1_count, t1_tick);

    // No pulse in a cycle that writes the timer
    assign t0_ovf = t0_step.ovf && !(wr_t0_low || wr_t0_high);
    assign t1_ovf = t1_step.ovf && !(wr_t1_low || wr_t1_high);

    // A software write to a byte wins over that byte's count update
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            t0_count <= {TCU_RESET_BYTE, TCU_RESET_BYTE};
        end else begin
            t0_count[7:0] <= wr_t0_low ? sfr_wdata_i : t0_step.count[7:0];
            t0_count[15:8] <= wr_t0_high ? sfr_wdata_i : t0_step.count[15:8];
        end
    end

    // Same write priority for timer 1
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            t1_count <= {TCU_RESET_BYTE, TCU_RESET_BYTE};
        end else begin
            t1_count[7:0] <= wr_t1_low ? sfr_wdata_i : t1_step.count[7:0];
            t1_count[15:8] <= wr_t1_high ? sfr_wdata_i : t1_step.count[15:8];
        end
    end

    // Timer 2 datapath
    assign t2_src = auxiliary_control_one[TCU_AUX_T2_SRC_POS] ? slow_tick : pin_fall[TCU_EDGE_T2];
    assign t2_tick = t2_ctl.run && (t2_ctl.ctr_sel ? t2_src : sys_tick);
    assign t2_ovf = t2_tick && (t2_count == 16'hFFFF);
    assign t2_baud = t2_ctl.rx_baud || t2_ctl.tx_baud;
    assign t2_auto = !t2_ctl.cap_mode || t2_baud;
    assign t2_trig = t2_ctl.ext_en && pin_fall[TCU_EDGE_TRIG];
    assign t2_reload = t2_auto && (t2_ovf || t2_trig);
    assign t2_capture = !t2_auto && t2_trig;

    // In capture mode the overflow simply wraps to zero
    always_comb begin
        next_t2_count = t2_count;
        if (t2_reload) begin
            next_t2_count = t2_rc;
        end else if (t2_tick) begin
            next_t2_count = t2_count + 16'h0001;
        end
    end

    // Bytes unlatched: a 16-bit read can tear
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            t2_count <= {TCU_RESET_BYTE, TCU_RESET_BYTE};
        end else begin
            t2_count[7:0] <= wr_t2_low ? sfr_wdata_i : next_t2_count[7:0];
            t2_count[15:8] <= wr_t2_high ? sfr_wdata_i : next_t2_count[15:8];
        end
    end

    // A capture wins over a software write to the same register
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            t2_rc <= {TCU_RESET_BYTE, TCU_RESET_BYTE};
        end else if (t2_capture) begin
            t2_rc <= t2_count;
        end else begin
            if (wr_rc_low) begin
                t2_rc[7:0] <= sfr_wdata_i;
            end
            if (wr_rc_high) begin
                t2_rc[15:8] <= sfr_wdata_i;
            end
        end
    end

    // Hardware sets of both flags win over a software clear in the same cycle
    always_comb begin
        next_t2_ctl = t2_ctl;
        if (sfr_wr_i && (sfr_addr_i == TCU_ADDR_T2_CTRL)) begin
            next_t2_ctl = tcu_t2ctl_type'(sfr_wdata_i);
        end
        if (t2_ovf && !t2_baud) begin
            next_t2_ctl.ovf_flag = 1'b1;
        end
        if (t2_trig) begin
            next_t2_ctl.ext_flag = 1'b1;
        end
    end

    // Flags live in the control register
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            t2_ctl <= tcu_t2ctl_type'(TCU_RESET_BYTE);
        end else begin
            t2_ctl <= next_t2_ctl;
        end
    end

    // Overflow pulses and baud clock routing
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            timer0_overflow_o <= 1'b0;
            timer1_overflow_o <= 1'b0;
            timer2_overflow_o <= 1'b0;
            uart_rx_baud_tick_o <= 1'b0;
            uart_tx_baud_tick_o <= 1'b0;
        end else begin
            timer0_overflow_o <= t0_ovf;
            timer1_overflow_o <= t1_ovf;
            timer2_overflow_o <= t2_ovf;
            uart_rx_baud_tick_o <= t2_ctl.rx_baud ? t2_ovf : t1_ovf;
            uart_tx_baud_tick_o <= t2_ctl.tx_baud ? t2_ovf : t1_ovf;
        end
    end

    // Read data follows the address by one cycle
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sfr_rdata_o <= TCU_UNMAPPED_BYTE;
        end else begin
            case (sfr_addr_i)
                TCU_ADDR_T01_MODE: sfr_rdata_o <= t01_mode;
                TCU_ADDR_T0_LOW: sfr_rdata_o <= t0_count[7:0];
                TCU_ADDR_T0_HIGH: sfr_rdata_o <= t0_count[15:8];
                TCU_ADDR_T1_LOW: sfr_rdata_o <= t1_count[7:0];
                TCU_ADDR_T1_HIGH: sfr_rdata_o <= t1_count[15:8];
                TCU_ADDR_T2_CTRL: sfr_rdata_o <= t2_ctl;
                TCU_ADDR_T2_RC_LOW: sfr_rdata_o <= t2_rc[7:0];
                TCU_ADDR_T2_RC_HIGH: sfr_rdata_o <= t2_rc[15:8];
                TCU_ADDR_T2_LOW: sfr_rdata_o <= t2_count[7:0];
                TCU_ADDR_T2_HIGH: sfr_rdata_o <= t2_count[15:8];
                TCU_ADDR_AUXILIARY_CONTROL_ONE: sfr_rdata_o <= auxiliary_control_one;
                default: sfr_rdata_o <= TCU_UNMAPPED_BYTE;
            endcase
        end
    end
endmodule : tcu_top
`default_nettype wire

// File: verification/tcu_top_asserts.sv
// Purpose: Port-level checks of the timer/counter unit.
// Assumes: Timer 2 control bits 5..0 change only by bus writes.
// Notes: Software-owned bits are shadowed from the write strobe.
`timescale 1ns/1ps
`default_nettype none
module tcu_top_asserts
    import tcu_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic timer0_run_i,
    input wire logic timer1_run_i,
    input wire logic timer0_ext_count_pin_i,
    input wire logic timer1_ext_count_pin_i,
    input wire logic timer2_ext_count_pin_i,
    input wire logic timer2_trigger_pin_i,
    input wire logic slow_oscillator_clock_i,
    input wire logic timer0_overflow_o,
    input wire logic timer1_overflow_o,
    input wire logic timer2_overflow_o,
    input wire logic uart_rx_baud_tick_o,
    input wire logic uart_tx_baud_tick_o
);
    tcu_t2ctl_type ctl_sh;
    logic [7:0] aux_sh;
    logic mapped;
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctl_sh <= '0;
        end else if (sfr_wr_i && sfr_addr_i == TCU_ADDR_T2_CTRL) begin
            ctl_sh <= tcu_t2ctl_type'(sfr_wdata_i);
        end
    end
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            aux_sh <= 8'h00;
        end else if (sfr_wr_i && sfr_addr_i == TCU_ADDR_AUXILIARY_CONTROL_ONE) begin
            aux_sh <= sfr_wdata_i;
        end
    end
    assign mapped = sfr_addr_i inside {[TCU_ADDR_T01_MODE:TCU_ADDR_T1_HIGH], TCU_ADDR_T2_CTRL,
        [TCU_ADDR_T2_RC_LOW:TCU_ADDR_T2_HIGH], TCU_ADDR_AUXILIARY_CONTROL_ONE};
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    // Four samples cover the write-to-output latency
    sequence s_t2_stopped;
        !ctl_sh.run [*4];
    endsequence
    sequence s_rx_t1;
        !ctl_sh.rx_baud [*4];
    endsequence
    sequence s_tx_t1;
        !ctl_sh.tx_baud [*4];
    endsequence
    chk_rst_quiet: assert property (disable iff (1'b0) sys_rst_i |->
        sfr_rdata_o == 8'h00 && !timer2_overflow_o && !uart_tx_baud_tick_o)
        else $error("outputs not quiet in reset");
    chk_rst_release: assert property (disable iff (1'b0) $fell(sys_rst_i) |->
        sfr_rdata_o == 8'h00 && !timer0_overflow_o && !timer1_overflow_o)
        else $error("outputs not zero after reset release");
    chk_unmapped_zero: assert property (!mapped |=> sfr_rdata_o == TCU_UNMAPPED_BYTE)
        else $error("unmapped read not zero");
    chk_aux_readback: assert property ((sfr_addr_i == TCU_ADDR_AUXILIARY_CONTROL_ONE && !sfr_wr_i)
        |=> sfr_rdata_o == $past(aux_sh))
        else $error("aux readback wrong");
    chk_t0_pulse: assert property (timer0_overflow_o |=> !timer0_overflow_o)
        else $error("timer 0 overflow on consecutive cycles");
    chk_t2_pulse: assert property (timer2_overflow_o |=> !timer2_overflow_o)
        else $error("timer 2 overflow on consecutive cycles");
    chk_t2_hold: assert property (s_t2_stopped |-> !timer2_overflow_o)
        else $error("timer 2 overflow while stopped");
    chk_rx_from_t1: assert property (s_rx_t1 |-> uart_rx_baud_tick_o == timer1_overflow_o)
        else $error("receive baud tick not timer 1 overflow");
    chk_tx_from_t1: assert property (s_tx_t1 |-> uart_tx_baud_tick_o == timer1_overflow_o)
        else $error("transmit baud tick not timer 1 overflow");
endmodule : tcu_top_asserts
`default_nettype wire

// File: verification/tcu_pin_model.sv
// Purpose: Drives the external count, trigger and slow clock pins.
// Assumes: Requests come at least eight cycles apart per lane.
// Notes: Each request gives one low pulse of three cycles; pins idle high.
`timescale 1ns/1ps
`default_nettype none
module tcu_pin_model
    import tcu_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic [TCU_EDGE_COUNT-1:0] fall_req_i,
    output logic [TCU_EDGE_COUNT-1:0] pin_o
);
    int low_cnt [TCU_EDGE_COUNT];
    initial pin_o = '1;
    // Levels last longer than the two-cycle synchroniser needs
    always @(posedge sys_clk_i) begin
        for (int i = 0; i < TCU_EDGE_COUNT; i++) begin
            if (fall_req_i[i]) begin
                low_cnt[i] = 3;
            end else if (low_cnt[i] > 0) begin
                low_cnt[i] = low_cnt[i] - 1;
            end
            pin_o[i] <= (low_cnt[i] == 0);
        end
    end
endmodule : tcu_pin_model
`default_nettype wire

// File: verification/tcu_top_test.sv
// Purpose: Self-checking bench of the timer/counter unit.
// Assumes: Register reads return data one cycle after the address.
// Notes: Count windows are exact edge counts, so tick phase does not matter.
`timescale 1ns/1ps
`default_nettype none
module tcu_top_test;
    import tcu_pkg::*;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } tcu_row_type;
    localparam tcu_row_type ROWS [11] = '{'{8'h8A, 8'hA5, 8'hA5}, '{8'h8B, 8'h5A, 8'h5A},
        '{8'h8C, 8'h3C, 8'h3C}, '{8'h8D, 8'hC3, 8'hC3}, '{8'hCA, 8'h12, 8'h12},
        '{8'hCB, 8'h34, 8'h34}, '{8'hCC, 8'h56, 8'h56}, '{8'hCD, 8'h78, 8'h78},
        '{8'h89, 8'h33, 8'h33}, '{8'hF8, 8'hA5, 8'hA5}, '{8'h90, 8'hFF, 8'h00}};
    logic sys_clk_i, sys_rst_i, sfr_wr_i, timer0_run_i, timer1_run_i;
    logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
    logic timer0_overflow_o, timer1_overflow_o, timer2_overflow_o;
    logic uart_rx_baud_tick_o, uart_tx_baud_tick_o;
    logic timer0_ext_count_pin_i, timer1_ext_count_pin_i, timer2_ext_count_pin_i;
    logic timer2_trigger_pin_i, slow_oscillator_clock_i;
    logic [4:0] fall_req, pins, ev;
    int error_cnt, n_tests;
    int evt [5];
    assign timer0_ext_count_pin_i = pins[TCU_EDGE_T0];
    assign timer1_ext_count_pin_i = pins[TCU_EDGE_T1];
    assign timer2_ext_count_pin_i = pins[TCU_EDGE_T2];
    assign timer2_trigger_pin_i = pins[TCU_EDGE_TRIG];
    assign slow_oscillator_clock_i = pins[TCU_EDGE_SLOW];
    assign ev = {uart_tx_baud_tick_o, uart_rx_baud_tick_o, timer2_overflow_o,
        timer1_overflow_o, timer0_overflow_o};
    tcu_top u_tcu_top (.*);
    tcu_pin_model u_tcu_pin_model (.sys_clk_i(sys_clk_i), .fall_req_i(fall_req), .pin_o(pins));
    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        for (int i = 0; i < 5; i++) begin
            if (ev[i] === 1'b1) evt[i]++;
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : tick
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One idle cycle after each write keeps the strobe from being driven twice at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        tick(1);
        sfr_wr_i = 1'b0;
        tick(1);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr_i = a;
        tick(1);
        check($sformatf("register %h", a), sfr_rdata_o, exp);
    endtask : rd_chk
    task automatic pin_fall(input int lane, input int n);
        repeat (n) begin
            fall_req[lane] = 1'b1;
            tick(1);
            fall_req[lane] = 1'b0;
            tick(7);
        end
    endtask : pin_fall
    task automatic print_verdict();
        $display("Counts: %0d checks, %0d errors", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #2000000;
        error_cnt++;
        print_verdict();
    end
    initial begin
        sys_rst_i = 1'b1;
        sfr_addr_i = 8'h00;
        sfr_wdata_i = 8'h00;
        sfr_wr_i = 1'b0;
        timer0_run_i = 1'b0;
        timer1_run_i = 1'b0;
        fall_req = '0;
        repeat (12) @(posedge sys_clk_i);
        #1;
        sys_rst_i = 1'b0;
        foreach (ROWS[i]) rd_chk(ROWS[i].addr, 8'h00);
        rd_chk(TCU_ADDR_T2_CTRL, 8'h00);
        $display("Test reset values done");
        foreach (ROWS[i]) begin
            wr(ROWS[i].addr, ROWS[i].wdata);
            rd_chk(ROWS[i].addr, ROWS[i].exp);
        end
        $display("Test register table done");
        wr(8'h89, 8'h01);
        wr(8'h8A, 8'hF8);
        wr(8'h8C, 8'h12);
        timer0_run_i = 1'b1;
        tick(20);
        timer0_run_i = 1'b0;
        rd_chk(8'h8A, 8'h02);
        rd_chk(8'h8C, 8'h13);
        wr(8'h89, 8'h00);
        wr(8'h8A, 8'hFC);
        wr(8'h8C, 8'hFF);
        evt = '{default: 0};
        timer0_run_i = 1'b1;
        tick(20);
        timer0_run_i = 1'b0;
        rd_chk(8'h8A, 8'hE6);
        rd_chk(8'h8C, 8'h00);
        check("timer 0 overflows", evt[0][7:0], 8'h01);
        wr(8'h89, 8'h02);
        wr(8'h8A, 8'hFE);
        wr(8'h8C, 8'hF0);
        timer0_run_i = 1'b1;
        tick(8);
        timer0_run_i = 1'b0;
        rd_chk(8'h8A, 8'hF2);
        $display("Test timer 0 modes done");
        wr(8'h89, 8'h50);
        wr(8'hF8, 8'h00);
        wr(8'h8B, 8'hFE);
        wr(8'h8D, 8'hFF);
        evt = '{default: 0};
        timer1_run_i = 1'b1;
        pin_fall(TCU_EDGE_T1, 3);
        rd_chk(8'h8B, 8'h01);
        check("timer 1 overflows", evt[1][7:0], 8'h01);
        check("receive baud ticks", evt[3][7:0], 8'h01);
        check("transmit baud ticks", evt[4][7:0], 8'h01);
        wr(8'hF8, 8'h02);
        pin_fall(TCU_EDGE_SLOW, 32);
        pin_fall(TCU_EDGE_T1, 2);
        timer1_run_i = 1'b0;
        rd_chk(8'h8B, 8'h03);
        $display("Test timer 1 counter done");
        wr(8'hCC, 8'h00);
        wr(8'hCD, 8'h00);
        wr(8'hC8, 8'h04);
        tick(18);
        wr(8'hC8, 8'h00);
        rd_chk(8'hCC, 8'h0A);
        tick(10);
        rd_chk(8'hCC, 8'h0A);
        wr(8'hC8, 8'h06);
        pin_fall(TCU_EDGE_T2, 3);
        wr(8'hC8, 8'h00);
        rd_chk(8'hCC, 8'h0D);
        $display("Test timer 2 count done");
        wr(8'hCA, 8'hFE);
        wr(8'hCB, 8'hFF);
        wr(8'hCC, 8'hFE);
        wr(8'hCD, 8'hFF);
        wr(8'hC8, 8'h04);
        tick(10);
        rd_chk(8'hC8, 8'h84);
        wr(8'hC8, 8'h80);
        rd_chk(8'hCD, 8'hFF);
        tick(10);
        rd_chk(8'hC8, 8'h80);
        wr(8'hC8, 8'h00);
        rd_chk(8'hC8, 8'h00);
        evt = '{default: 0};
        wr(8'hC8, 8'h35);
        tick(10);
        rd_chk(8'hC8, 8'h35);
        wr(8'hC8, 8'h00);
        rd_chk(8'hCD, 8'hFF);
        check("timer 2 receive baud", 8'(evt[3] != 0), 8'h01);
        check("timer 2 transmit baud", 8'(evt[4] != 0), 8'h01);
        check("timer 2 overflows", 8'(evt[2] != 0), 8'h01);
        $display("Test timer 2 reload and baud done");
        wr(8'hCC, 8'h78);
        wr(8'hCD, 8'h56);
        wr(8'hC8, 8'h09);
        pin_fall(TCU_EDGE_TRIG, 1);
        rd_chk(8'hCA, 8'h78);
        rd_chk(8'hCB, 8'h56);
        rd_chk(8'hC8, 8'h49);
        wr(8'hC8, 8'h01);
        wr(8'hCC, 8'h00);
        pin_fall(TCU_EDGE_TRIG, 1);
        rd_chk(8'hCA, 8'h78);
        rd_chk(8'hC8, 8'h01);
        wr(8'hC8, 8'h08);
        pin_fall(TCU_EDGE_TRIG, 1);
        rd_chk(8'hCC, 8'h78);
        $display("Test timer 2 capture done");
        sys_rst_i = 1'b1;
        tick(2);
        sys_rst_i = 1'b0;
        rd_chk(8'hCB, 8'h00);
        rd_chk(8'hC8, 8'h00);
        $display("Test mid-run reset done");
        print_verdict();
    end
endmodule : tcu_top_test
bind tcu_top tcu_top_asserts u_tcu_top_asserts (.*);
`default_nettype wire
